// ### presence_ctrl.sv
// Presence detector control: remote lock, restart behaviour, PIR settings,
// interlock lockout and brightness transmission, with an APB register file.
// Assumes bus telegram inputs are one-cycle pulses synchronous to CORE_CLK.
//
// What this block does
// [RULE_01] Remote lock works only when configured.
// [RULE_02] Lock object toggles lock, configurable polarity.
// [RULE_03] Locked remote commands are all rejected.
// [RULE_04] Bus return: unlocked, locked, or saved state.
// [RULE_05] Reprogramming starts lock unlocked or locked.
// [RULE_06] Bus return delays feedback by min:sec.
// [RULE_07] Reprogramming sends feedback without delay.
// [RULE_08] Units get separate return and reprogram behaviour.
// [RULE_09] Unprogrammed: no motion telegrams, remote enabled.
// [RULE_10] Bad or missing application: idle, slow blink.
// [RULE_11] Low basic sensitivity caps all sectors.
// [RULE_12] Three sectors: off, 25 to 100 percent.
// [RULE_13] Enabled adjuster shifts all sectors one level.
// [RULE_14] Matching interlock telegram suppresses motion detection.
// [RULE_15] New matching telegram restarts the lockout.
// [RULE_16] Lockout time 0 to 59 seconds.
// [RULE_17] Brightness sent on change, cyclic, both, read.
// [RULE_18] Change sends need a configured lux step.
// [RULE_19] Adjuster shift clamps at end levels.
// [RULE_20] Lux step in 5 lux increments, default 20.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module presence_ctrl #(
   parameter int SEC_CYCLES = presence_pkg::SEC_CYCLES,
   parameter int BLINK_HALF_CYCLES = presence_pkg::BLINK_HALF_CYCLES,
   parameter int SECTORS = 3
) (
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic LOCK_OBJ_VALID,
   input wire logic LOCK_OBJ_VALUE,
   input wire logic INTERLOCK_VALID,
   input wire logic INTERLOCK_VALUE,
   input wire logic IR_CMD_VALID,
   input wire logic [SECTORS-1:0] MOTION_IN,
   input wire logic BUS_RETURN,
   input wire logic SUPPLY_FAIL,
   input wire logic REPROG_DONE,
   input wire logic [15:0] BRIGHT_SAMPLE,
   input wire logic BRIGHT_SAMPLE_VALID,
   input wire logic BRIGHT_READ_REQ,
   output logic IR_ACCEPT,
   output logic LOCK_STATE,
   output logic [SECTORS-1:0] MOTION_OUT,
   output logic MOTION_TELEGRAM,
   output logic FEEDBACK_SEND,
   output logic UNIT_RESTART,
   output logic RESTART_CAUSE,
   output logic BRIGHT_SEND,
   output logic [15:0] BRIGHT_DATA,
   output logic STATUS_LED
);
   logic [31:0] cfg_reg;
   logic [31:0] sens_reg;
   logic [31:0] time_reg;
   logic [31:0] cycle_reg;
   logic pready_reg;
   logic lock_reg;
   logic saved_lock_reg;
   logic [31:0] blink_cnt_reg;
   logic led_reg;
   logic [3*SECTORS-1:0] eff_sens;
   logic [31:0] status;
   logic wr_en;
   logic lock_active;
   logic functional;
   logic il_match;
   logic delay_done_seen;
   logic [11:0] delay_secs;

   sec_timer_if delay_if ();
   sec_timer_if lockout_if ();
   sec_timer_if cycle_if ();

   // Register transfer completes at the edge where the slave shows ready.
   assign wr_en = PSEL && PENABLE && pready_reg && PWRITE;
   assign functional = cfg_reg[presence_pkg::CFG_PROGRAMMED] &&
                       !cfg_reg[presence_pkg::CFG_APP_BAD];
   assign lock_active = cfg_reg[presence_pkg::CFG_LOCK_EN] && lock_reg && // RULE_01
                        cfg_reg[presence_pkg::CFG_PROGRAMMED]; // RULE_09
   assign delay_secs = 12'(cfg_field6(time_reg, presence_pkg::TIME_DMIN_LO) *
                       presence_pkg::SECS_PER_MIN) +
                       12'(cfg_field6(time_reg, presence_pkg::TIME_DSEC_LO));

   function automatic logic [5:0] cfg_field6(input logic [31:0] r, input int lo);
      cfg_field6 = r[lo +: presence_pkg::FIELD6_W];
   endfunction

   // APB access phase answers one cycle after it starts.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         pready_reg <= 1'b0;
         PRDATA <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else begin
         pready_reg <= PSEL && PENABLE && !pready_reg;
         PSLVERR <= 1'b0;
         if (PSEL && PENABLE && !pready_reg) begin
            PRDATA <= 32'h0000_0000;
            unique case (PADDR)
               presence_pkg::ADDR_CFG: PRDATA <= cfg_reg;
               presence_pkg::ADDR_SENS: PRDATA <= sens_reg;
               presence_pkg::ADDR_TIME: PRDATA <= time_reg;
               presence_pkg::ADDR_CYCLE: PRDATA <= cycle_reg;
               presence_pkg::ADDR_STATUS: PRDATA <= status;
               presence_pkg::ADDR_BRIGHT: PRDATA <= {16'h0000, BRIGHT_DATA};
               default: PSLVERR <= 1'b1;
            endcase
         end
      end
   end
   assign PREADY = pready_reg;

   // Software-written configuration registers.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         cfg_reg <= presence_pkg::CFG_RST;
         sens_reg <= presence_pkg::SENS_RST; // RULE_12
         time_reg <= presence_pkg::TIME_RST; // RULE_16
         cycle_reg <= presence_pkg::CYCLE_RST;
      end else if (wr_en) begin
         if (PADDR == presence_pkg::ADDR_CFG) begin
            cfg_reg <= PWDATA;
         end
         if (PADDR == presence_pkg::ADDR_SENS) begin
            sens_reg <= PWDATA;
         end
         if (PADDR == presence_pkg::ADDR_TIME) begin
            time_reg <= PWDATA; // RULE_20
         end
         if (PADDR == presence_pkg::ADDR_CYCLE) begin
            cycle_reg <= PWDATA;
         end
      end
   end

   // Remote lock state: bus object, bus return and reprogramming.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         lock_reg <= 1'b0;
      end else if (REPROG_DONE) begin
         lock_reg <= cfg_reg[presence_pkg::CFG_PROG_LOCK]; // RULE_05
      end else if (BUS_RETURN) begin
         unique case (cfg_reg[presence_pkg::CFG_BVR_LO +: 2]) // RULE_04
            presence_pkg::LR_OFF: lock_reg <= 1'b0;
            presence_pkg::LR_ON: lock_reg <= 1'b1;
            presence_pkg::LR_SAVED: lock_reg <= saved_lock_reg;
            default: lock_reg <= 1'b0;
         endcase
      end else if (LOCK_OBJ_VALID) begin
         lock_reg <= LOCK_OBJ_VALUE ^ cfg_reg[presence_pkg::CFG_LOCK_INV]; // RULE_02
      end
   end

   // Lock state is kept across a supply failure.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         saved_lock_reg <= 1'b0;
      end else if (SUPPLY_FAIL) begin
         saved_lock_reg <= lock_reg; // RULE_04
      end
   end

   // Remote commands pass unless locked; a dead application takes none.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         IR_ACCEPT <= 1'b0;
         LOCK_STATE <= 1'b0;
      end else begin
         IR_ACCEPT <= IR_CMD_VALID && !lock_active && !cfg_reg[presence_pkg::CFG_APP_BAD]; // RULE_03
         LOCK_STATE <= lock_active;
      end
   end

   // Per-sector sensitivity with adjuster shift and basic cap.
   for (genvar s = 0; s < SECTORS; s++) begin : g_sector
      logic [2:0] base;
      logic [2:0] shifted;
      always_comb begin
         base = sens_reg[s*presence_pkg::SENS_STRIDE +: 3];
         shifted = base;
         if (cfg_reg[presence_pkg::CFG_ADJ_EN]) begin // RULE_13
            if (cfg_reg[presence_pkg::CFG_SHIFT_LO +: 2] == presence_pkg::SH_UP &&
                base < presence_pkg::LEVEL_MAX) begin // RULE_19
               shifted = base + presence_pkg::LEVEL_ONE;
            end else if (cfg_reg[presence_pkg::CFG_SHIFT_LO +: 2] == presence_pkg::SH_DOWN &&
                         base > presence_pkg::LEVEL_OFF) begin // RULE_19
               shifted = base - presence_pkg::LEVEL_ONE;
            end
         end
         if (shifted > presence_pkg::LEVEL_MAX) begin
            shifted = presence_pkg::LEVEL_MAX; // RULE_19
         end
         if (cfg_reg[presence_pkg::CFG_BASIC_LOW] &&
             shifted > presence_pkg::LEVEL_BASIC_LOW) begin
            shifted = presence_pkg::LEVEL_BASIC_LOW; // RULE_11
         end
      end
      assign eff_sens[s*3 +: 3] = shifted;

      // Motion passes for a live sector outside the lockout.
      always_ff @(posedge CORE_CLK or posedge RESET) begin
         if (RESET) begin
            MOTION_OUT[s] <= 1'b0;
         end else begin
            MOTION_OUT[s] <= MOTION_IN[s] && (shifted != presence_pkg::LEVEL_OFF) && // RULE_12
                             !lockout_if.busy && !cfg_reg[presence_pkg::CFG_APP_BAD]; // RULE_14
         end
      end
   end

   // Interlock telegram matches the configured polarity.
   always_comb begin
      unique case (cfg_reg[presence_pkg::CFG_IL_LO +: 2])
         presence_pkg::IL_OFF: il_match = INTERLOCK_VALID && !INTERLOCK_VALUE;
         presence_pkg::IL_ON: il_match = INTERLOCK_VALID && INTERLOCK_VALUE;
         presence_pkg::IL_BOTH: il_match = INTERLOCK_VALID;
         default: il_match = 1'b0;
      endcase
   end
   assign lockout_if.load = il_match; // RULE_15
   assign lockout_if.value = 12'(cfg_field6(time_reg, presence_pkg::TIME_LOCK_LO)); // RULE_16

   // Restart delay is armed on bus return only.
   assign delay_if.load = BUS_RETURN && !REPROG_DONE; // RULE_06
   assign delay_if.value = delay_secs;
   assign delay_done_seen = delay_if.done;

   // Cyclic brightness timer re-arms whenever idle and a cycle is set.
   assign cycle_if.value = 12'(cfg_field6(cycle_reg, presence_pkg::TIME_DMIN_LO) *
                           presence_pkg::SECS_PER_MIN) +
                           12'(cfg_field6(cycle_reg, presence_pkg::TIME_DSEC_LO));
   assign cycle_if.load = !cycle_if.busy && !cycle_if.done && (cycle_if.value != 12'h000);

   sec_timer #(.SEC_CYCLES(SEC_CYCLES)) u_delay (.clk(CORE_CLK), .rst(RESET), .tif(delay_if));
   sec_timer #(.SEC_CYCLES(SEC_CYCLES)) u_lockout (.clk(CORE_CLK), .rst(RESET), .tif(lockout_if));
   sec_timer #(.SEC_CYCLES(SEC_CYCLES)) u_cycle (.clk(CORE_CLK), .rst(RESET), .tif(cycle_if));

   // Feedback release and unit restart notices.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         FEEDBACK_SEND <= 1'b0;
         UNIT_RESTART <= 1'b0;
         RESTART_CAUSE <= 1'b0;
         MOTION_TELEGRAM <= 1'b0;
      end else begin
         FEEDBACK_SEND <= functional && (REPROG_DONE || delay_done_seen); // RULE_07
         UNIT_RESTART <= REPROG_DONE || BUS_RETURN; // RULE_08
         if (REPROG_DONE || BUS_RETURN) begin
            RESTART_CAUSE <= REPROG_DONE; // RULE_08
         end
         MOTION_TELEGRAM <= functional && (|MOTION_OUT); // RULE_09
      end
   end

   // Slow blink while the application cannot run.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         blink_cnt_reg <= 32'h0000_0000;
         led_reg <= 1'b0;
      end else if (!cfg_reg[presence_pkg::CFG_APP_BAD]) begin
         blink_cnt_reg <= 32'h0000_0000;
         led_reg <= 1'b0;
      end else if (blink_cnt_reg == 32'(BLINK_HALF_CYCLES - 1)) begin
         blink_cnt_reg <= 32'h0000_0000;
         led_reg <= !led_reg; // RULE_10
      end else begin
         blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
      end
   end
   assign STATUS_LED = led_reg;

   bright_tx u_bright (
      .clk(CORE_CLK),
      .rst(RESET),
      .enable(functional),
      .mode(cfg_reg[presence_pkg::CFG_BM_LO +: 2]),
      .step_lux(time_reg[presence_pkg::TIME_STEP_LO +: 8]),
      .sample(BRIGHT_SAMPLE),
      .sample_valid(BRIGHT_SAMPLE_VALID),
      .read_req(BRIGHT_READ_REQ),
      .cycle_done(cycle_if.done),
      .send(BRIGHT_SEND),
      .data(BRIGHT_DATA)
   );

   // Status word shows lock, timers, indicator and effective levels.
   always_comb begin
      status = 32'h0000_0000;
      status[presence_pkg::ST_LOCK] = lock_active;
      status[presence_pkg::ST_DELAY] = delay_if.busy;
      status[presence_pkg::ST_LOCKOUT] = lockout_if.busy;
      status[presence_pkg::ST_LED] = led_reg;
      status[presence_pkg::ST_EFF_LO +: 3*SECTORS] = eff_sens;
   end

   // Checks on the behaviour above.
   ir_lock_gate_a: assert property (@(posedge CORE_CLK) disable iff (RESET) // RULE_03
      IR_CMD_VALID && lock_active |=> !IR_ACCEPT)
      else $error("Remote command accepted while locked.");
   ir_unlocked_a: assert property (@(posedge CORE_CLK) disable iff (RESET) // RULE_01
      IR_CMD_VALID && !cfg_reg[presence_pkg::CFG_LOCK_EN] && !cfg_reg[presence_pkg::CFG_APP_BAD]
      |=> IR_ACCEPT)
      else $error("Remote command dropped with lock disabled.");
   bvr_lock_a: assert property (@(posedge CORE_CLK) disable iff (RESET) // RULE_04
      BUS_RETURN && !REPROG_DONE && cfg_reg[presence_pkg::CFG_BVR_LO +: 2] == presence_pkg::LR_SAVED
      |=> lock_reg == $past(saved_lock_reg))
      else $error("Saved lock state not restored.");
   prog_lock_a: assert property (@(posedge CORE_CLK) disable iff (RESET) // RULE_05
      REPROG_DONE |=> lock_reg == $past(cfg_reg[presence_pkg::CFG_PROG_LOCK]))
      else $error("Lock state after reprogramming wrong.");
   prog_nodelay_a: assert property (@(posedge CORE_CLK) disable iff (RESET) // RULE_07
      REPROG_DONE && functional |=> FEEDBACK_SEND)
      else $error("Feedback delayed after reprogramming.");
   bvr_delay_a: assert property (@(posedge CORE_CLK) disable iff (RESET) // RULE_06
      BUS_RETURN && !REPROG_DONE && delay_secs != 12'h000 |=> !FEEDBACK_SEND ##1 delay_if.busy)
      else $error("Feedback not held back after bus return.");
   lockout_supp_a: assert property (@(posedge CORE_CLK) disable iff (RESET) // RULE_14
      il_match && time_reg[presence_pkg::TIME_LOCK_LO +: 6] != 6'h00
      |=> lockout_if.busy ##1 MOTION_OUT == '0)
      else $error("Motion passed during lockout.");
   unprog_quiet_a: assert property (@(posedge CORE_CLK) disable iff (RESET) // RULE_09
      !cfg_reg[presence_pkg::CFG_PROGRAMMED] |=> !MOTION_TELEGRAM)
      else $error("Motion telegram sent while unprogrammed.");
   sens_cap_a: assert property (@(posedge CORE_CLK) disable iff (RESET) // RULE_11
      cfg_reg[presence_pkg::CFG_BASIC_LOW] |-> eff_sens[2:0] <= presence_pkg::LEVEL_BASIC_LOW)
      else $error("Basic sensitivity cap not applied.");
   cover_lock_ir_c: cover property (@(posedge CORE_CLK) disable iff (RESET)
      lock_active && IR_CMD_VALID);
   cover_lockout_c: cover property (@(posedge CORE_CLK) disable iff (RESET)
      lockout_if.busy && il_match);
   cover_bvr_send_c: cover property (@(posedge CORE_CLK) disable iff (RESET)
      delay_if.done && FEEDBACK_SEND == 1'b0);
endmodule // presence_ctrl
`default_nettype wire

// ### presence_pkg.sv
// Shared constants for the presence detector control block: register map,
// field positions, reset values, mode encodings and timing figures.
// Assumes a single 20 MHz core clock and a 32-bit APB register bus.
package presence_pkg;
   // Core clock and derived timing figures.
   localparam int CLK_HZ = 20_000_000;
   localparam int SECOND_S = 1;
   localparam int SEC_CYCLES = SECOND_S * CLK_HZ;
   localparam int BLINK_MILLIHZ = 750;
   localparam int BLINK_HALF_CYCLES = int'((64'(CLK_HZ) * 64'd1000) / (64'd2 * 64'(BLINK_MILLIHZ)));
   localparam int SECS_PER_MIN = 60;
   // Register byte addresses.
   localparam logic [7:0] ADDR_CFG = 8'h00;
   localparam logic [7:0] ADDR_SENS = 8'h04;
   localparam logic [7:0] ADDR_TIME = 8'h08;
   localparam logic [7:0] ADDR_CYCLE = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_BRIGHT = 8'h14;
   // Configuration register fields.
   localparam int CFG_LOCK_EN = 0;
   localparam int CFG_LOCK_INV = 1;
   localparam int CFG_BVR_LO = 2;
   localparam int CFG_PROG_LOCK = 4;
   localparam int CFG_BASIC_LOW = 5;
   localparam int CFG_ADJ_EN = 6;
   localparam int CFG_IL_LO = 7;
   localparam int CFG_BM_LO = 9;
   localparam int CFG_PROGRAMMED = 11;
   localparam int CFG_APP_BAD = 12;
   localparam int CFG_SHIFT_LO = 13;
   // Timing register fields.
   localparam int TIME_DMIN_LO = 0;
   localparam int TIME_DSEC_LO = 8;
   localparam int TIME_LOCK_LO = 16;
   localparam int TIME_STEP_LO = 24;
   localparam int FIELD6_W = 6;
   // Sensitivity fields, one nibble per sector.
   localparam int SENS_STRIDE = 4;
   // Status register fields.
   localparam int ST_LOCK = 0;
   localparam int ST_DELAY = 1;
   localparam int ST_LOCKOUT = 2;
   localparam int ST_LED = 3;
   localparam int ST_EFF_LO = 4;
   // Reset values.
   localparam logic [31:0] CFG_RST = 32'h0000_0100;
   localparam logic [31:0] SENS_RST = 32'h0000_0444;
   localparam logic [31:0] TIME_RST = 32'h1403_1100;
   localparam logic [31:0] CYCLE_RST = 32'h0000_0003;
   // Sensitivity levels: off, 25, 50, 75 and 100 percent.
   localparam logic [2:0] LEVEL_OFF = 3'h0;
   localparam logic [2:0] LEVEL_MAX = 3'h4;
   localparam logic [2:0] LEVEL_BASIC_LOW = 3'h2;
   localparam logic [2:0] LEVEL_ONE = 3'h1;
   typedef enum logic [1:0] {LR_OFF = 2'b00, LR_ON = 2'b01, LR_SAVED = 2'b10} lock_restart_t;
   typedef enum logic [1:0] {IL_OFF = 2'b00, IL_ON = 2'b01, IL_BOTH = 2'b10} interlock_pol_t;
   typedef enum logic [1:0] {BM_CHANGE = 2'b00, BM_CYCLIC = 2'b01, BM_BOTH = 2'b10,
                             BM_READ = 2'b11} bright_mode_t;
   typedef enum logic [1:0] {SH_NONE = 2'b00, SH_UP = 2'b01, SH_DOWN = 2'b10} shift_t;
endpackage

// ### sec_timer_if.sv
// Interface joining a controller to a whole-second countdown timer.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface sec_timer_if;
   logic load;
   logic [11:0] value;
   logic busy;
   logic done;
   modport ctrl (output load, output value, input busy, input done);
   modport timer (input load, input value, output busy, output done);
endinterface
`default_nettype wire

// ### sec_timer.sv
// Whole-second countdown timer; a load restarts it from its full value.
// Assumes load is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sec_timer #(
   parameter int SEC_CYCLES = presence_pkg::SEC_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   sec_timer_if.timer tif
);
   logic [31:0] cyc_reg;
   logic [11:0] sec_reg;
   logic done_reg;

   // Counts seconds down; a load re-arms the sub-second prescaler too.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cyc_reg <= 32'h0000_0000;
         sec_reg <= 12'h000;
         done_reg <= 1'b0;
      end else if (tif.load) begin
         cyc_reg <= 32'(SEC_CYCLES - 1);
         sec_reg <= tif.value;
         done_reg <= (tif.value == 12'h000); // A zero time ends at once.
      end else if (sec_reg != 12'h000) begin
         done_reg <= 1'b0;
         if (cyc_reg == 32'h0000_0000) begin
            cyc_reg <= 32'(SEC_CYCLES - 1);
            sec_reg <= sec_reg - 12'h001;
            done_reg <= (sec_reg == 12'h001);
         end else begin
            cyc_reg <= cyc_reg - 32'h0000_0001;
         end
      end else begin
         done_reg <= 1'b0;
      end
   end

   assign tif.busy = (sec_reg != 12'h000);
   assign tif.done = done_reg;
endmodule // sec_timer
`default_nettype wire

// ### bright_tx.sv
// Decides when the 2-byte measured brightness object is sent.
// Assumes sample_valid, read_req and cycle_done are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module bright_tx (
   input wire logic clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic [1:0] mode,
   input wire logic [7:0] step_lux,
   input wire logic [15:0] sample,
   input wire logic sample_valid,
   input wire logic read_req,
   input wire logic cycle_done,
   output logic send,
   output logic [15:0] data
);
   logic [15:0] diff;
   logic on_change;
   logic cyclic;

   // Change and cycle conditions for the configured mode.
   always_comb begin
      diff = (sample >= data) ? sample - data : data - sample;
      on_change = (mode == presence_pkg::BM_CHANGE) || (mode == presence_pkg::BM_BOTH);
      cyclic = (mode == presence_pkg::BM_CYCLIC) || (mode == presence_pkg::BM_BOTH);
   end

   // Sends on a large enough change, on the cycle, or on a read request.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         send <= 1'b0;
         data <= 16'h0000;
      end else begin
         send <= 1'b0;
         if (enable && (read_req || (cyclic && cycle_done) || // RULE_17
             (on_change && sample_valid && diff >= {8'h00, step_lux}))) begin // RULE_18
            send <= 1'b1;
            data <= sample;
         end
      end
   end
endmodule // bright_tx
`default_nettype wire

// ### knx_bus_model.sv
// Bus-side model: other subscribers sending one-bit telegrams to the block.
// Assumes every call starts just after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module knx_bus_model (
   input wire logic clk,
   output logic lk_v,
   output logic lk_d,
   output logic il_v,
   output logic il_d
);
   // The bus is idle at time zero.
   initial {lk_v, lk_d, il_v, il_d} = 4'h0;
   // Holds one telegram for one cycle, then leaves the inverse value on the idle line.
   task automatic send(input logic il, input logic d);
      if (il) begin
         il_v <= 1'b1;
         il_d <= d;
      end else begin
         lk_v <= 1'b1;
         lk_d <= d;
      end
      @(posedge clk);
      {lk_v, il_v} <= 2'h0;
      if (il) il_d <= ~d;
      else lk_d <= ~d;
   endtask
endmodule // knx_bus_model
`default_nettype wire

// ### testbench.sv
// Self-checking bench for presence_ctrl.
// Assumes the design package, its modules and knx_bus_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int SC = 20;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pready, pslverr, lk_v, lk_d, il_v, il_d;
   logic ir_acc, lock, mtel, fb, bsend, urs, rc, led;
   logic [2:0] min = 0, mout;
   logic [5:0] ev = 0;
   logic [7:0] paddr = 0;
   logic [15:0] bs = 0, bdata, lfsr = 16'hF9B2, last = 0, v;
   logic [31:0] pwdata = 0, prdata;
   logic [31:0] tcfg[3] = '{32'h0000_2940, 32'h0000_4940, 32'h0000_2920};
   logic [8:0] teff[3] = '{9'h10A, 9'h0C0, 9'h081};
   logic [32:0] rd_q[$], br_q[$];
   int fb_q[$], errors = 0, num_checks = 0, since = 0, cyc = 0;
   // Core clock of 50 ns.
   always #25 clk = ~clk;
   // Design with short second and blink counts.
   presence_ctrl #(.SEC_CYCLES(SC), .BLINK_HALF_CYCLES(10)) DUT (.CORE_CLK(clk), .RESET(rst),
      .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LOCK_OBJ_VALID(lk_v),
      .LOCK_OBJ_VALUE(lk_d), .INTERLOCK_VALID(il_v), .INTERLOCK_VALUE(il_d),
      .IR_CMD_VALID(ev[3]), .MOTION_IN(min), .BUS_RETURN(ev[0]), .SUPPLY_FAIL(ev[2]),
      .REPROG_DONE(ev[1]), .BRIGHT_SAMPLE(bs), .BRIGHT_SAMPLE_VALID(ev[4]),
      .BRIGHT_READ_REQ(ev[5]), .IR_ACCEPT(ir_acc), .LOCK_STATE(lock), .MOTION_OUT(mout),
      .MOTION_TELEGRAM(mtel), .FEEDBACK_SEND(fb), .UNIT_RESTART(urs), .RESTART_CAUSE(rc),
      .BRIGHT_SEND(bsend), .BRIGHT_DATA(bdata), .STATUS_LED(led));
   knx_bus_model bus (.clk(clk), .lk_v(lk_v), .lk_d(lk_d), .il_v(il_v), .il_d(il_d));
   // Pseudo-random values from a 16-bit shift register.
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction
   // Counts a comparison and reports a mismatch.
   task automatic cmp(string n, logic [32:0] e, logic [32:0] s);
      num_checks++;
      if (e !== s) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // One-cycle event pulse on input k.
   task automatic pulse(int k);
      ev[k] <= 1'b1;
      @(posedge clk);
      ev <= 6'h00;
   endtask
   // One APB transfer; waits for pready before releasing the request.
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      {psel, pen, pwr, paddr, pwdata} <= {2'h2, w, a, d};
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      {psel, pen} <= 2'h0;
      @(posedge clk);
   endtask
   // Notes the expected error flag and data, then reads.
   task automatic rd(logic [7:0] a, logic [32:0] e);
      rd_q.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   // Sends one remote button and checks whether it was taken.
   task automatic irt(logic e);
      logic a;
      pulse(3);
      @(posedge clk);
      a = ir_acc;
      @(posedge clk);
      cmp("remote accept", e, a | ir_acc);
   endtask
   // Watches the outputs and compares each read, feedback and brightness result with the oldest note.
   always @(posedge clk) begin
      since = (ev[0] || ev[1]) ? 0 : since + 1;
      cyc = cyc + 1;
      if (psel && pen && pready === 1'b1 && !pwr) cmp("read", rd_q.pop_front(), {pslverr, prdata});
      if (fb === 1'b1) cmp("feedback", fb_q.size() ? fb_q.pop_front() : -1, since);
      if (urs === 1'b1) cmp("restart", 1, since);
      if (bsend === 1'b1) cmp("brightness", br_q.size() ? br_q.pop_front() : 'x, bdata);
      if (cyc > 5000) begin
         errors++;
         stop_test();
      end
   end
   // Main sequence of tests.
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(8'h00, 33'h0_0000_0100);
      rd(8'h04, 33'h0_0000_0444);
      rd(8'h08, 33'h0_1403_1100);
      rd(8'h0C, 33'h0_0000_0003);
      rd(8'h18, 33'h1_0000_0000);
      min <= 3'h7;
      irt(1'b1);
      cmp("motion telegram", 0, mtel);
      $display("test registers done");
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, 8'h00, 32'h0000_0900 | (i > 0) | (i == 2) << 1);
         bus.send(1'b0, i != 2);
         repeat (2) @(posedge clk);
         cmp("lock", i > 0, lock);
         irt(i == 0);
         bus.send(1'b0, i == 2);
         repeat (2) @(posedge clk);
         irt(1'b1);
      end
      $display("test remote lock done");
      apb(1'b1, 8'h08, 32'h1402_0100);
      for (int m = 0; m < 3; m++) begin
         apb(1'b1, 8'h00, 32'h0000_0901 | m << 2 | (m & 1) << 4);
         bus.send(1'b0, 1'b1);
         pulse(2);
         bus.send(1'b0, 1'b0);
         fb_q.push_back(SC + 2);
         pulse(0);
         repeat (30) @(posedge clk);
         cmp("lock after return", m > 0, {rc, lock});
         fb_q.push_back(1);
         pulse(1);
         repeat (3) @(posedge clk);
         cmp("lock after reprogram", 2 | m & 1, {rc, lock});
      end
      apb(1'b1, 8'h08, 32'h1402_0000);
      fb_q.push_back(2);
      pulse(0);
      repeat (5) @(posedge clk);
      $display("test restart done");
      apb(1'b1, 8'h04, 32'h0000_0401);
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, 8'h00, tcfg[k]);
         rd(8'h10, 33'(teff[k]) << 4);
      end
      apb(1'b1, 8'h00, 32'h0000_0880);
      min <= 3'(rnd()) | 3'h1;
      bus.send(1'b1, 1'b0);
      repeat (3) @(posedge clk);
      cmp("motion", min & 3'h5, mout);
      cmp("motion telegram", 1, mtel);
      bus.send(1'b1, 1'b1);
      repeat (30) @(posedge clk);
      cmp("motion locked", 0, mout);
      bus.send(1'b1, 1'b1);
      repeat (30) @(posedge clk);
      cmp("motion relocked", 0, mout);
      repeat (15) @(posedge clk);
      cmp("motion free", min & 3'h5, mout);
      $display("test motion done");
      for (int j = 0; j < 8; j++) begin
         v = (j < 2) ? 16'(20 + 19 * j) : last + 16'(rnd() % 40);
         bs <= v;
         if (v - last >= 20) begin
            br_q.push_back(v);
            last = v;
         end
         pulse(4);
         repeat (2) @(posedge clk);
      end
      apb(1'b1, 8'h00, 32'h0000_0C80);
      br_q.push_back(v);
      wait (bsend === 1'b1);
      apb(1'b1, 8'h00, 32'h0000_0E80);
      pulse(4);
      @(posedge clk);
      br_q.push_back(v);
      pulse(5);
      repeat (3) @(posedge clk);
      cmp("pending sends", 0, fb_q.size() + br_q.size());
      apb(1'b1, 8'h00, 32'h0000_1000);
      repeat (12) @(posedge clk);
      cmp("blink", 1, led);
      $display("test brightness done");
      stop_test();
   end
endmodule // testbench
`default_nettype wire
